// ---- logic/uec_pkg.sv ----
// constants for the endpoint control set/clear ports and dma next-descriptor registers
package uec_pkg;
  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int NUM_EP = 7;
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int DESC_LSB = 4;
  localparam int DESC_W = DATA_W - DESC_LSB;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SET_BASE = 12'h01F0;
  localparam logic [ADDR_W-1:0] CLR_BASE = 12'h0220;
  localparam logic [ADDR_W-1:0] EP_STRIDE = 12'h0004;
  localparam logic [ADDR_W-1:0] DESC_BASE = 12'h0310;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 12'h0010;

  // --------------------------------------------------------------
  // endpoint control field positions
  // --------------------------------------------------------------
  localparam int B_STALL = 19;
  localparam int B_TOGGLE = 18;
  localparam int B_DMA_PAUSE = 16;
  localparam int B_BANK_CTRL = 14;
  localparam int B_KILL = 13;
  localparam int B_BUSY = 12;
  localparam int IRQ_EN_W = 8;
  localparam logic [DATA_W-1:0] SET_MASK = 32'h000D_30FF;
  localparam logic [DATA_W-1:0] CLR_MASK = 32'h0009_50FF;

  // --------------------------------------------------------------
  // reset values and bus answers
  // --------------------------------------------------------------
  localparam logic [DATA_W-1:0] EP_CTRL_RST = 32'h0000_0000;
  localparam logic [DESC_W-1:0] DESC_RST = 28'h000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ---- logic/uec_ep_ctrl.sv ----
// one endpoint's control bits, driven by set and clear port writes and hardware events
`timescale 1ns/100ps
module uec_ep_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // port writes, strobe-masked data
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [uec_pkg::DATA_W-1:0] wbits,
  // hardware events
  input wire logic kill_done,
  input wire logic setup_rx,
  input wire logic bank_ready,
  // control state
  output logic [uec_pkg::DATA_W-1:0] ctrl_q
);
  import uec_pkg::*;

  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] set_bits;
  logic [DATA_W-1:0] clr_bits;

  // --------------------------------------------------------------
  // next state: hardware clears, then software clears, then sets
  // --------------------------------------------------------------
  always_comb begin
    set_bits = set_we ? (wbits & SET_MASK) : '0; // RULE_02
    clr_bits = clr_we ? (wbits & CLR_MASK) : '0; // RULE_02
    ctrl_d = ctrl_q;
    ctrl_d[B_TOGGLE] = 1'b0; // RULE_18
    if (kill_done) begin
      ctrl_d[B_KILL] = 1'b0; // RULE_17
    end
    if (setup_rx) begin
      ctrl_d[B_STALL] = 1'b0; // RULE_19
    end
    // RULE_01 RULE_08 RULE_09 RULE_10 RULE_11
    ctrl_d = ctrl_d & ~clr_bits;
    if (bank_ready) begin
      ctrl_d[B_BANK_CTRL] = 1'b1; // hardware set beats software clear
    end
    // RULE_03 RULE_05 RULE_06 RULE_07 RULE_08 RULE_10 RULE_11
    ctrl_d = ctrl_d | set_bits;
  end

  // register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= EP_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_tog_req;
    set_we && wbits[B_TOGGLE];
  endsequence
  sequence s_tog_idle;
    !(set_we && wbits[B_TOGGLE]);
  endsequence

  a_irq_set: assert property (set_we && wbits[0] |=> ctrl_q[0]) // RULE_03
    else $error("irq enable set lost");
  a_irq_clr: assert property (clr_we && wbits[7] && !(set_we && wbits[7]) |=> !ctrl_q[7]) // RULE_01
    else $error("irq enable clear lost");
  a_zero_keep: assert property (!(set_we && wbits[B_DMA_PAUSE]) && !(clr_we && wbits[B_DMA_PAUSE])
    |=> $stable(ctrl_q[B_DMA_PAUSE])) // RULE_02
    else $error("zero write changed dma pause");
  a_kill_done: assert property (ctrl_q[B_KILL] && kill_done && !(set_we && wbits[B_KILL])
    |=> !ctrl_q[B_KILL]) // RULE_17
    else $error("kill request not cleared");
  a_kill_hold: assert property (ctrl_q[B_KILL] && !kill_done |=> ctrl_q[B_KILL]) // RULE_06
    else $error("kill request dropped early");
  a_toggle_pulse: assert property (s_tog_req ##1 s_tog_idle |-> ctrl_q[B_TOGGLE] ##1 !ctrl_q[B_TOGGLE]) // RULE_07
    else $error("toggle reset not a single pulse");
  a_stall_setup: assert property (setup_rx && !(set_we && wbits[B_STALL]) |=> !ctrl_q[B_STALL]) // RULE_19
    else $error("stall kept after setup");
  a_bank_clr: assert property (clr_we && wbits[B_BANK_CTRL] && !bank_ready |=> !ctrl_q[B_BANK_CTRL]) // RULE_09
    else $error("bank flag not cleared");
  a_busy_pair: assert property ((set_we || clr_we) && wbits[B_BUSY] |=> ctrl_q[B_BUSY] == $past(set_we)) // RULE_11
    else $error("busy bank enable set/clear wrong");
endmodule

// ---- logic/uec_regs.sv ----
// AXI4-Lite register bank: endpoint control set/clear ports and dma next-descriptor pointers
// Contract
// (RULE_01) clear port bits clear interrupt enables
// (RULE_02) zero writes no effect, ports read zero
// (RULE_03) set port bits set interrupt enables
// (RULE_04) set ports at 0x01F0 plus 4 per endpoint
// (RULE_05) set port bit layout fixed
// (RULE_06) kill bit sets kill request
// (RULE_07) toggle bit sets toggle reset request
// (RULE_08) stall set and clear bits
// (RULE_09) clear port clears bank control flag
// (RULE_10) dma pause enable set and clear
// (RULE_11) busy bank enable set and clear
// (RULE_12) next-descriptor per channel, reset zero
// (RULE_13) field holds descriptor address bits 31:4
// (RULE_14) software and dma both update pointer
// (RULE_15) low four bits ignored, read zero
// (RULE_16) clear ports at 0x0220 plus 4 per endpoint
// (RULE_17) hardware clears kill request when done
// (RULE_18) toggle reset forces next Data0
// (RULE_19) setup packet clears stall request
`timescale 1ns/100ps
module uec_regs #(
  parameter int N_EP = uec_pkg::NUM_EP,
  parameter int N_CH = uec_pkg::NUM_CH
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // axi4-lite write address
  input wire logic [uec_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [uec_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [uec_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [uec_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // endpoint hardware events, one bit per endpoint
  input wire logic [N_EP-1:0] KILL_DONE,
  input wire logic [N_EP-1:0] SETUP_RX,
  input wire logic [N_EP-1:0] BANK_READY,
  // endpoint control state, one word per endpoint
  output logic [N_EP*uec_pkg::DATA_W-1:0] EP_CTRL,
  // dma descriptor load, one slot per channel
  input wire logic [N_CH-1:0] DESC_LOAD,
  input wire logic [N_CH*uec_pkg::DESC_W-1:0] DESC_LOAD_ADDR,
  // next-descriptor pointers, one slot per channel
  output logic [N_CH*uec_pkg::DESC_W-1:0] NEXT_DESC
);
  import uec_pkg::*;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wbits;
  logic [N_EP-1:0] set_we;
  logic [N_EP-1:0] clr_we;
  logic [N_CH-1:0] desc_we;
  logic [DESC_W-1:0] desc_q [N_CH];
  logic [DESC_W-1:0] desc_d [N_CH];

  // --------------------------------------------------------------
  // address map helpers
  // --------------------------------------------------------------
  // true when the address hits any port or pointer
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int e = 0; e < N_EP; e++) begin
      if (a == ADDR_W'(SET_BASE + e * EP_STRIDE)) begin
        hit = 1'b1; // RULE_04
      end
      if (a == ADDR_W'(CLR_BASE + e * EP_STRIDE)) begin
        hit = 1'b1; // RULE_16
      end
    end
    for (int c = 0; c < N_CH; c++) begin
      if (a == ADDR_W'(DESC_BASE + c * CH_STRIDE)) begin
        hit = 1'b1; // RULE_12
      end
    end
    return hit;
  endfunction

  // read value: set and clear ports always read zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = READ_ZERO; // RULE_02
    for (int c = 0; c < N_CH; c++) begin
      if (a == ADDR_W'(DESC_BASE + c * CH_STRIDE)) begin
        v = {desc_q[c], {DESC_LSB{1'b0}}}; // RULE_13 RULE_15
      end
    end
    return v;
  endfunction

  // --------------------------------------------------------------
  // write channel: address and data taken in either order
  // --------------------------------------------------------------
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits = wdata_q & wmask;

  // next state of the write side
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
      awready_d = 1'b0;
    end
    if (S_AXI_WVALID && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
      wready_d = 1'b0;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
    end
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
  end

  // write side registers
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // --------------------------------------------------------------
  // read channel: one cycle from address to data
  // --------------------------------------------------------------
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (S_AXI_ARVALID && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = read_word(S_AXI_ARADDR);
      rresp_d = addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
    end
    if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  // read side registers
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= READ_ZERO;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // bus outputs straight from flops
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // --------------------------------------------------------------
  // endpoint control: one instance per endpoint
  // --------------------------------------------------------------
  for (genvar e = 0; e < N_EP; e++) begin : g_ep
    assign set_we[e] = wr_fire && (awaddr_q == ADDR_W'(SET_BASE + e * EP_STRIDE)); // RULE_04
    assign clr_we[e] = wr_fire && (awaddr_q == ADDR_W'(CLR_BASE + e * EP_STRIDE)); // RULE_16
    uec_ep_ctrl u_ep (
      .clk(CORE_CLK),
      .resetn(RESETN),
      .set_we(set_we[e]),
      .clr_we(clr_we[e]),
      .wbits(wbits),
      .kill_done(KILL_DONE[e]),
      .setup_rx(SETUP_RX[e]),
      .bank_ready(BANK_READY[e]),
      .ctrl_q(EP_CTRL[e*DATA_W +: DATA_W])
    );
  end

  // --------------------------------------------------------------
  // next-descriptor pointers
  // --------------------------------------------------------------
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    assign desc_we[c] = wr_fire && (awaddr_q == ADDR_W'(DESC_BASE + c * CH_STRIDE)); // RULE_12
    assign NEXT_DESC[c*DESC_W +: DESC_W] = desc_q[c];
  end

  // byte-merged software write; a dma load in the same cycle wins
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      desc_d[c] = desc_q[c];
      if (desc_we[c]) begin
        // RULE_13 RULE_15
        desc_d[c] = (desc_q[c] & ~wmask[DATA_W-1:DESC_LSB]) | wbits[DATA_W-1:DESC_LSB];
      end
      if (DESC_LOAD[c]) begin
        desc_d[c] = DESC_LOAD_ADDR[c*DESC_W +: DESC_W]; // RULE_14
      end
    end
  end

  // pointer registers
  always_ff @(posedge CORE_CLK) begin
    for (int c = 0; c < N_CH; c++) begin
      if (!RESETN) begin
        desc_q[c] <= DESC_RST; // RULE_12
      end else begin
        desc_q[c] <= desc_d[c];
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  a_port_read_zero: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == CLR_BASE
    |=> S_AXI_RVALID && S_AXI_RDATA == READ_ZERO && S_AXI_RRESP == RESP_OKAY) // RULE_02
    else $error("clear port did not read zero");
  a_desc_low_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[DESC_LSB-1:0] == 4'h0) // RULE_15
    else $error("pointer low bits not zero");
  a_desc_load: assert property (DESC_LOAD[0] |=> NEXT_DESC[DESC_W-1:0] == $past(DESC_LOAD_ADDR[DESC_W-1:0])) // RULE_14
    else $error("dma load not taken");
  a_desc_write: assert property (desc_we[1] && wstrb_q == 4'hF && !DESC_LOAD[1]
    |=> NEXT_DESC[2*DESC_W-1:DESC_W] == $past(wdata_q[DATA_W-1:DESC_LSB])) // RULE_13
    else $error("pointer write not stored");
  a_stall_write: assert property (set_we[0] && wbits[B_STALL] |=> EP_CTRL[B_STALL]) // RULE_08
    else $error("stall request not set");
  a_write_resp: assert property (wr_fire |=> S_AXI_BVALID && S_AXI_BRESP == (addr_mapped($past(awaddr_q))
    ? RESP_OKAY : RESP_DECERR)) // RULE_04
    else $error("write response wrong");
endmodule

// ---- verification/usb_ep_ctrl_set_clear_regs_tb.sv ----
// self-checking bench for the endpoint set/clear ports and next-descriptor registers
`timescale 1ns/100ps
module usb_ep_ctrl_set_clear_regs_tb;
  import uec_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, resetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [6:0] kill_done, setup_rx, bank_ready;
  logic [223:0] ep_ctrl, snap;
  logic [5:0] desc_load;
  logic [167:0] desc_load_addr, next_desc;
  logic [31:0] exp_ep [7];
  int err_count, checks_done;

  uec_regs i_uec_regs (.CORE_CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .KILL_DONE(kill_done), .SETUP_RX(setup_rx), .BANK_READY(bank_ready),
    .EP_CTRL(ep_ctrl), .DESC_LOAD(desc_load), .DESC_LOAD_ADDR(desc_load_addr), .NEXT_DESC(next_desc));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bounded wait ran out
  task automatic hang(input string name);
    err_count++;
    $display("BAD %s expected handshake seen none", name);
    stop_test();
  endtask

  // axi4-lite write, keeps ep_ctrl as seen at the response edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 50) hang("bvalid");
    r = bresp;
    snap = ep_ctrl;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 50) hang("rvalid");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // compare every endpoint word with the model
  task automatic check_all();
    #1;
    for (int e = 0; e < 7; e++) check("ep_ctrl", ep_ctrl[e*32+:32], exp_ep[e]);
  endtask

  // write a set (clr=0) or clear (clr=1) port and update the model
  task automatic wr_ep(input int e, input bit clr, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m, p;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) m[i*8+:8] = d[i*8+:8] & {8{s[i]}};
    p = 32'h0000_0000;
    if (clr) begin
      exp_ep[e] &= ~(m & 32'h0009_50FF);
    end else begin
      exp_ep[e] |= m & 32'h0009_30FF;
      p = m & 32'h0004_0000;
    end
    axi_wr((clr ? 12'h220 : 12'h1F0) + 12'(e * 4), d, s, r);
    check("ep_bresp", {30'h0, r}, 32'h0000_0000);
    check("ep_word", snap[e*32+:32], exp_ep[e] | p);
  endtask

  // one-cycle hardware event on one endpoint
  task automatic pulse(input int kind, input int e);
    @(posedge clk);
    if (kind == 0) kill_done[e] <= 1'b1;
    if (kind == 1) setup_rx[e] <= 1'b1;
    if (kind == 2) bank_ready[e] <= 1'b1;
    @(posedge clk);
    kill_done <= '0;
    setup_rx <= '0;
    bank_ready <= '0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  int bits [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 12, 13, 14, 16, 18, 19};

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check_all();
    for (int c = 0; c < 6; c++) begin
      axi_rd(12'h310 + 12'(c * 16), d, r);
      check("desc_reset", d, 32'h0000_0000);
      check("desc_slot", {4'h0, next_desc[c*28+:28]}, 32'h0000_0000);
    end
    $display("test reset done");
  endtask

  task automatic t_set_clear();
    logic [31:0] d;
    logic [1:0] r;
    for (int e = 0; e < 7; e++) begin
      foreach (bits[i]) wr_ep(e, 1'b0, 32'h1 << bits[i], 4'hF);
      wr_ep(e, 1'b0, 32'h0000_0000, 4'hF);
      axi_rd(12'h1F0 + 12'(e * 4), d, r);
      check("set_read", d, 32'h0000_0000);
      check("set_rresp", {30'h0, r}, 32'h0000_0000);
      axi_rd(12'h220 + 12'(e * 4), d, r);
      check("clr_read", d, 32'h0000_0000);
      check("clr_rresp", {30'h0, r}, 32'h0000_0000);
      foreach (bits[i]) wr_ep(e, 1'b1, 32'h1 << bits[i], 4'hF);
      check_all();
    end
    // strobes gate which bytes act
    wr_ep(2, 1'b0, 32'hFFFF_FFFF, 4'b0001);
    wr_ep(2, 1'b0, 32'hFFFF_FFFF, 4'b1110);
    wr_ep(2, 1'b1, 32'hFFFF_FFFF, 4'b0100);
    check_all();
    $display("test set_clear done");
  endtask

  task automatic t_hw_events();
    wr_ep(3, 1'b0, 32'hFFFF_FFFF, 4'hF);
    pulse(0, 3);
    exp_ep[3][13] = 1'b0;
    check_all();
    pulse(1, 3);
    exp_ep[3][19] = 1'b0;
    check_all();
    pulse(2, 3);
    exp_ep[3][14] = 1'b1;
    check_all();
    wr_ep(3, 1'b1, 32'h0000_4000, 4'hF);
    check_all();
    $display("test hw_events done");
  endtask

  task automatic t_desc();
    logic [31:0] d, v;
    logic [1:0] r;
    for (int c = 0; c < 6; c++) begin
      v = 32'hF0E1_D2CF - 32'(c) * 32'h0101_0101;
      axi_wr(12'h310 + 12'(c * 16), v, 4'hF, r);
      axi_wr(12'h310 + 12'(c * 16), 32'h0000_AB0F, 4'b0010, r);
      v = {v[31:16], 8'hAB, v[7:4], 4'h0};
      axi_rd(12'h310 + 12'(c * 16), d, r);
      check("desc_read", d, v);
      check("desc_slot", {4'h0, next_desc[c*28+:28]}, {4'h0, v[31:4]});
      @(posedge clk);
      desc_load[c] <= 1'b1;
      desc_load_addr[c*28+:28] <= 28'h0ABC_DE0 + 28'(c);
      @(posedge clk);
      desc_load <= '0;
      axi_rd(12'h310 + 12'(c * 16), d, r);
      check("desc_load", d, {28'h0ABC_DE0 + 28'(c), 4'h0});
    end
    $display("test desc done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(12'h20C, 32'hFFFF_FFFF, 4'hF, r);
    check("wr_decerr", {30'h0, r}, 32'h0000_0003);
    axi_wr(12'h23C, 32'hFFFF_FFFF, 4'hF, r);
    check("wr_decerr", {30'h0, r}, 32'h0000_0003);
    axi_rd(12'h370, d, r);
    check("rd_decerr", {30'h0, r}, 32'h0000_0003);
    check("rd_dec_data", d, 32'h0000_0000);
    check_all();
    $display("test unmapped done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {kill_done, setup_rx, bank_ready, desc_load} = '0;
    desc_load_addr = '0;
    snap = '0;
    foreach (exp_ep[e]) exp_ep[e] = 32'h0000_0000;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_set_clear();
    t_hw_events();
    t_desc();
    t_unmapped();
    stop_test();
  end
endmodule
